// file: hw/hppi_pkg.sv
package hppi_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int DW   = 16;
    localparam int AW   = 4;
    localparam int NREQ = 3;

    // Request pin index
    localparam int REQ_COMB = 0;
    localparam int REQ_TX   = 1;
    localparam int REQ_RX   = 2;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ   = 200;
    localparam int SETUP_NS  = 10;
    localparam int STB_NS    = 80;
    localparam int HOLD_NS   = 30;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STB_CYC   = (STB_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC  = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int STRAP_CYC = 4;

    // ****************************************
    // Controller register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_WDATA = 8'h04;
    localparam logic [7:0] OFS_RDATA = 8'h08;
    localparam logic [7:0] OFS_STAT  = 8'h0C;

    localparam int CB_START = 0;
    localparam int CB_DIR   = 1;
    localparam int CB_DUAL  = 2;
    localparam int CB_SPOL  = 3;
    localparam int CB_BYTE  = 4;
    localparam int CB_ACK   = 5;
    localparam int CB_STRAP = 6;
    localparam int CB_CSB   = 7;
    localparam int CB_ADDR  = 8;

    localparam int SB_BUSY  = 0;
    localparam int SB_REQ   = 1;

    localparam logic [31:0] CTRL_RST = 32'h0000_0008;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [1:0] {D_IDLE, D_READ, D_WRITE} hppi_dst_t;
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STB, H_HOLD} hppi_hst_t;

endpackage

// file: hw/hppi_if.sv
`timescale 1ns/1ps

interface hppi_if #(
    parameter int DW = hppi_pkg::DW,
    parameter int AW = hppi_pkg::AW,
    parameter int NR = hppi_pkg::NREQ
);
    logic          sel_a;
    logic          sel_b;
    logic          dir;
    logic          rd_stb;
    logic          wr_stb;
    logic          ds_stb;
    logic          spol;
    logic          dual;
    logic          byte_sel;
    logic          ack;
    logic          strap;
    logic [AW-1:0] regsel;
    logic [DW-1:0] data_h_o;
    logic          data_h_oe;
    logic [DW-1:0] data_d_o;
    logic          data_d_oe;
    logic [DW-1:0] data_lvl;
    logic [NR-1:0] req_o;
    logic [NR-1:0] req_oe;
    logic [NR-1:0] req_lvl;

    // Wire levels with pull-ups on undriven lines
    assign data_lvl = data_d_oe ? data_d_o : (data_h_oe ? data_h_o : {DW{1'b1}});
    assign req_lvl  = (req_oe & req_o) | ~req_oe;

    modport dev (
        input  sel_a, sel_b, dir, rd_stb, wr_stb, ds_stb, spol, dual, byte_sel,
        input  ack, strap, regsel, data_lvl,
        output data_d_o, data_d_oe, req_o, req_oe
    );

    modport host (
        output sel_a, sel_b, dir, rd_stb, wr_stb, ds_stb, spol, dual, byte_sel,
        output ack, strap, regsel, data_h_o, data_h_oe,
        input  data_lvl, req_lvl
    );
endinterface

// file: hw/hppi_sync.sv
`timescale 1ns/1ps

module hppi_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } hppi_sync_t;

    hppi_sync_t q;
    hppi_sync_t d;

    // A change counts once stages two and three agree
    always_comb begin
        d    = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.o  = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.o);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.o;
endmodule

// file: hw/hppi_dev.sv
`timescale 1ns/1ps

// Overview of operation
// - Port select is OR of both selects
// - Single strobe: direction pin picks read/write
// - Single strobe qualifies each access
// - Dual strobe: read strobe issues reads
// - Dual strobe: write strobe issues writes
// - Strobe polarity comes from polarity pin
// - Dual-strobe pin picks strobe style
// - Width pin picks 8 or 16 bits
// - Single request: one combined request, programmable polarity
// - Combined request driven or open drain
// - Dual request: transmit request output
// - Dual request: receive request output
// - Single request: acknowledge input with programmable polarity
// - Enabled port leaves upper system bits unused
// - Strap high at reset enables port
// - Narrow system bus before setting enable
// - Sixteen shared bidirectional host data lines
// - Four address lines select host register
module hppi_dev #(
    parameter int DW = hppi_pkg::DW,
    parameter int AW = hppi_pkg::AW,
    parameter int NR = hppi_pkg::NREQ
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Host pins
    hppi_if.dev                pins,
    // Port configuration
    input  wire logic          port_enable_bit,
    input  wire logic          bus_width_select_bit,
    input  wire logic          req_pol,
    input  wire logic          req_od,
    input  wire logic          dual_req,
    input  wire logic          ack_pol,
    // Requests toward the host
    input  wire logic          tx_req,
    input  wire logic          rx_req,
    // Host register access
    output logic               reg_wr,
    output logic               reg_rd,
    output logic      [AW-1:0] reg_addr,
    output logic      [DW-1:0] reg_wdata,
    input  wire logic [DW-1:0] reg_rdata,
    // Status
    output logic               host_ack,
    output logic               port_active,
    // Shared upper system data bits
    input  wire logic [DW-1:0] sys_hi_o,
    input  wire logic          sys_hi_oe,
    output logic      [DW-1:0] sys_hi_i
);
    // ****************************************
    // Types and state
    // ****************************************
    typedef struct packed {
        logic          sel_a;
        logic          sel_b;
        logic          dir;
        logic          rd;
        logic          wr;
        logic          ds;
        logic          spol;
        logic          dual;
        logic          byte_sel;
        logic          ack;
        logic          strap;
        logic [AW-1:0] regsel;
        logic [DW-1:0] data;
    } hppi_dpin_t;

    typedef struct packed {
        hppi_pkg::hppi_dst_t st;
        logic [2:0]          cnt;
        logic                strap_done;
        logic                strap;
        logic                en;
        logic [AW-1:0]       addr;
        logic [DW-1:0]       dout;
        logic [DW-1:0]       wdata;
        logic [DW-1:0]       sys_i;
        logic                wr_p;
        logic                rd_p;
        logic                ack;
        logic [NR-1:0]       ro;
        logic [NR-1:0]       roe;
    } hppi_dstate_t;

    hppi_dstate_t q;
    hppi_dstate_t d;
    hppi_dpin_t   raw;
    hppi_dpin_t   s;
    logic         sel;
    logic         act_rd;
    logic         act_wr;
    logic [DW-1:0] bmask;
    logic [NR-1:0] want;
    logic [NR-1:0] used;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    assign raw = '{sel_a: pins.sel_a, sel_b: pins.sel_b, dir: pins.dir,
                   rd: pins.rd_stb, wr: pins.wr_stb, ds: pins.ds_stb,
                   spol: pins.spol, dual: pins.dual, byte_sel: pins.byte_sel,
                   ack: pins.ack, strap: pins.strap, regsel: pins.regsel,
                   data: pins.data_lvl};

    hppi_sync #(
        .W($bits(hppi_dpin_t))
    ) hppi_sync_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (raw),
        .dout    (s)
    );

    // ****************************************
    // Access decode
    // ****************************************
    assign sel    = s.sel_a | s.sel_b;
    // Strobe level equal to the polarity pin means active
    assign act_rd = sel & (s.dual ? (s.rd == s.spol)
                                  : (s.ds == s.spol) & s.dir);
    assign act_wr = sel & (s.dual ? (s.wr == s.spol)
                                  : (s.ds == s.spol) & ~s.dir);
    assign bmask  = s.byte_sel ? {{(DW-8){1'b0}}, 8'hFF} : {DW{1'b1}};

    assign want[hppi_pkg::REQ_COMB] = tx_req | rx_req;
    assign want[hppi_pkg::REQ_TX]   = tx_req;
    assign want[hppi_pkg::REQ_RX]   = rx_req;
    assign used[hppi_pkg::REQ_COMB] = ~dual_req;
    assign used[hppi_pkg::REQ_TX]   = dual_req;
    assign used[hppi_pkg::REQ_RX]   = dual_req;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d      = q;
        d.wr_p = 1'b0;
        d.rd_p = 1'b0;

        // Strap is caught once the synchroniser has settled after reset
        if (!q.strap_done) begin
            if (q.cnt == 3'(hppi_pkg::STRAP_CYC)) begin
                d.strap      = s.strap;
                d.strap_done = 1'b1;
            end else begin
                d.cnt = q.cnt + 3'h1;
            end
        end
        d.en = q.strap | (port_enable_bit & bus_width_select_bit);

        case (q.st)
            hppi_pkg::D_IDLE: begin
                // Inputs ignored while the port is off
                if (q.en && act_rd) begin
                    d.addr = s.regsel;
                    d.rd_p = 1'b1;
                    d.st   = hppi_pkg::D_READ;
                end else if (q.en && act_wr) begin
                    d.addr  = s.regsel;
                    d.wdata = s.data & bmask;
                    d.st    = hppi_pkg::D_WRITE;
                end
            end
            hppi_pkg::D_READ: begin
                d.dout = reg_rdata & bmask;
                if (!act_rd || !q.en) begin
                    d.st = hppi_pkg::D_IDLE;
                end
            end
            hppi_pkg::D_WRITE: begin
                if (!q.en) begin
                    d.st = hppi_pkg::D_IDLE;
                end else if (act_wr) begin
                    d.wdata = s.data & bmask;
                end else begin
                    d.wr_p = 1'b1;
                    d.st   = hppi_pkg::D_IDLE;
                end
            end
            default: begin
                d.st = hppi_pkg::D_IDLE;
            end
        endcase

        // Request pins: polarity, and open drain only pulls low
        for (int i = 0; i < NR; i++) begin
            d.ro[i]  = req_od ? 1'b0 : ~(want[i] ^ req_pol);
            d.roe[i] = q.en & used[i] & (~req_od | (want[i] ^ req_pol));
        end

        d.ack   = q.en & ~dual_req & (s.ack == ack_pol);
        d.sys_i = q.en ? {DW{1'b0}} : s.data;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q    <= '0;
            q.st <= hppi_pkg::D_IDLE;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign pins.data_d_o  = q.en ? q.dout : sys_hi_o;
    assign pins.data_d_oe = q.en ? (q.st == hppi_pkg::D_READ) : sys_hi_oe;
    assign pins.req_o     = q.ro;
    assign pins.req_oe    = q.roe;
    assign reg_wr         = q.wr_p;
    assign reg_rd         = q.rd_p;
    assign reg_addr       = q.addr;
    assign reg_wdata      = q.wdata;
    assign host_ack       = q.ack;
    assign port_active    = q.en;
    assign sys_hi_i       = q.sys_i;
endmodule

// file: hw/hppi_host.sv
`timescale 1ns/1ps

module hppi_host #(
    parameter int DW = hppi_pkg::DW,
    parameter int AW = hppi_pkg::AW,
    parameter int NR = hppi_pkg::NREQ
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host pins
    hppi_if.host             pins
);
    typedef struct packed {
        hppi_pkg::hppi_hst_t st;
        logic [4:0]          cnt;
        logic [31:0]         ctrl;
        logic [DW-1:0]       wdata;
        logic [DW-1:0]       rdata;
    } hppi_hstate_t;

    hppi_hstate_t          q;
    hppi_hstate_t          d;
    logic [DW+NR-1:0]      sin;
    logic [DW-1:0]         sdata;
    logic [NR-1:0]         sreq;
    logic                  busy;
    logic                  stb;
    logic                  apb_wr;
    logic                  mapped;
    logic                  dir;
    logic                  spol;
    logic                  dual;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    hppi_sync #(
        .W(DW + NR)
    ) hppi_sync_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({pins.req_lvl, pins.data_lvl}),
        .dout    (sin)
    );
    assign {sreq, sdata} = sin;

    // ****************************************
    // APB decode
    // ****************************************
    assign busy   = (q.st != hppi_pkg::H_IDLE);
    assign stb    = (q.st == hppi_pkg::H_STB);
    assign apb_wr = psel & penable & pwrite;
    assign mapped = (paddr == hppi_pkg::OFS_CTRL) || (paddr == hppi_pkg::OFS_WDATA)
                 || (paddr == hppi_pkg::OFS_RDATA) || (paddr == hppi_pkg::OFS_STAT);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        case (paddr)
            hppi_pkg::OFS_CTRL:  prdata = {q.ctrl[31:1], busy};
            hppi_pkg::OFS_WDATA: prdata = {{(32-DW){1'b0}}, q.wdata};
            hppi_pkg::OFS_RDATA: prdata = {{(32-DW){1'b0}}, q.rdata};
            hppi_pkg::OFS_STAT:  prdata = {{(31-NR){1'b0}}, sreq, busy};
            default:             prdata = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Transfer sequencer
    // ****************************************
    always_comb begin
        d = q;
        if (apb_wr && paddr == hppi_pkg::OFS_WDATA && !busy) begin
            d.wdata = pwdata[DW-1:0];
        end
        case (q.st)
            hppi_pkg::H_IDLE: begin
                // Configuration only changes between transfers
                if (apb_wr && paddr == hppi_pkg::OFS_CTRL) begin
                    d.ctrl = pwdata & 32'h0000_0FFE;
                    if (pwdata[hppi_pkg::CB_START]) begin
                        d.st  = hppi_pkg::H_SETUP;
                        d.cnt = 5'(hppi_pkg::SETUP_CYC - 1);
                    end
                end
            end
            hppi_pkg::H_SETUP: begin
                d.cnt = q.cnt - 5'h1;
                if (q.cnt == 5'h00) begin
                    d.st  = hppi_pkg::H_STB;
                    d.cnt = 5'(hppi_pkg::STB_CYC - 1);
                end
            end
            hppi_pkg::H_STB: begin
                d.cnt = q.cnt - 5'h1;
                if (q.cnt == 5'h00) begin
                    if (q.ctrl[hppi_pkg::CB_DIR]) begin
                        d.rdata = q.ctrl[hppi_pkg::CB_BYTE] ? {{(DW-8){1'b0}}, sdata[7:0]}
                                                            : sdata;
                    end
                    d.st  = hppi_pkg::H_HOLD;
                    d.cnt = 5'(hppi_pkg::HOLD_CYC - 1);
                end
            end
            hppi_pkg::H_HOLD: begin
                d.cnt = q.cnt - 5'h1;
                if (q.cnt == 5'h00) begin
                    d.st = hppi_pkg::H_IDLE;
                end
            end
            default: begin
                d.st = hppi_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q      <= '0;
            q.st   <= hppi_pkg::H_IDLE;
            q.ctrl <= hppi_pkg::CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    assign dir  = q.ctrl[hppi_pkg::CB_DIR];
    assign spol = q.ctrl[hppi_pkg::CB_SPOL];
    assign dual = q.ctrl[hppi_pkg::CB_DUAL];

    assign pins.sel_a     = busy & ~q.ctrl[hppi_pkg::CB_CSB];
    assign pins.sel_b     = busy & q.ctrl[hppi_pkg::CB_CSB];
    assign pins.dir       = dir;
    assign pins.ds_stb    = (stb & ~dual) ? spol : ~spol;
    assign pins.rd_stb    = (stb & dual & dir) ? spol : ~spol;
    assign pins.wr_stb    = (stb & dual & ~dir) ? spol : ~spol;
    assign pins.spol      = spol;
    assign pins.dual      = dual;
    assign pins.byte_sel  = q.ctrl[hppi_pkg::CB_BYTE];
    assign pins.ack       = q.ctrl[hppi_pkg::CB_ACK];
    assign pins.strap     = q.ctrl[hppi_pkg::CB_STRAP];
    assign pins.regsel    = q.ctrl[hppi_pkg::CB_ADDR +: AW];
    assign pins.data_h_o  = q.wdata;
    assign pins.data_h_oe = busy & ~dir;
endmodule

// file: dv/hppi_monitor.sv
`timescale 1ns/1ps

module hppi_monitor (
    // Clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // Host pins
    input wire logic                    sel_a,
    input wire logic                    sel_b,
    input wire logic                    dir,
    input wire logic                    rd_stb,
    input wire logic                    wr_stb,
    input wire logic                    ds_stb,
    input wire logic                    spol,
    input wire logic                    dual,
    input wire logic [hppi_pkg::AW-1:0] regsel,
    input wire logic [hppi_pkg::DW-1:0] data_h_o,
    input wire logic                    data_h_oe,
    input wire logic                    data_d_oe
);
    // ****************************************
    // Helper logic
    // ****************************************
    logic       sel;
    logic       act;
    logic       wr_act;
    logic [5:0] cnt_q;

    assign sel    = sel_a | sel_b;
    assign act    = dual ? (rd_stb == spol || wr_stb == spol) : (ds_stb == spol);
    assign wr_act = dual ? (wr_stb == spol) : (ds_stb == spol && !dir);

    // Length of the current active strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= act ? cnt_q + 6'h01 : 6'h00;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking mon_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rd_start;
        $rose(data_d_oe);
    endsequence
    sequence s_stb_start;
        $rose(act) && $stable(spol);
    endsequence
    sequence s_stb_end;
        $fell(act) && $stable(spol);
    endsequence

    chk_no_clash: assert property (!(data_d_oe && data_h_oe))
        else $error("Both ends drive the data lines");
    chk_rd_cause: assert property (s_rd_start |->
        (dual ? rd_stb == spol : dir && ds_stb == spol))
        else $error("Device drives data without a read strobe");
    chk_rd_sel: assert property (s_rd_start |-> sel && $past(sel, 3))
        else $error("Device drives data while not selected");
    chk_rd_release: assert property ($fell(data_d_oe) |-> !act)
        else $error("Device released data during an active strobe");
    chk_stb_excl: assert property (dual |-> !(rd_stb == spol && wr_stb == spol))
        else $error("Read and write strobes active together");
    chk_stb_setup: assert property (s_stb_start |-> sel && $past(sel))
        else $error("Strobe active without a settled select");
    chk_stb_width: assert property (s_stb_end |-> cnt_q == 6'(hppi_pkg::STB_CYC))
        else $error("Strobe length wrong");
    chk_wr_data: assert property (wr_act && $past(wr_act) |->
        data_h_oe && $stable(data_h_o))
        else $error("Write data not held during the strobe");
    chk_regsel_held: assert property (act && $past(act) |->
        $stable(regsel) && $stable(dir))
        else $error("Register select moved during the strobe");
endmodule

// file: dv/hppi_test.sv
`timescale 1ns/1ps

module hppi_test;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic        pclk = 1'b0, presetn = 1'b0, dev_rstn = 1'b1, dev_rn;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        peb = 1'b0, bws = 1'b0, req_pol = 1'b0, req_od = 1'b0, dual_req = 1'b0;
    logic        ack_pol = 1'b0, tx_req = 1'b0, rx_req = 1'b0;
    logic        reg_wr, reg_rd, host_ack, port_active;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, sys_hi_i;
    logic [15:0] mem [16];
    logic [19:0] wq [$];
    logic [3:0]  rq [$];
    logic [19:0] wn;
    int          bad_count = 0, checked = 0, seed = 46;

    always #2.5 pclk = ~pclk;
    assign dev_rn    = presetn & dev_rstn;
    assign reg_rdata = mem[reg_addr];

    hppi_if hppi_if_inst ();
    hppi_dev hppi_dev_inst (.pclk(pclk), .presetn(dev_rn), .pins(hppi_if_inst),
        .port_enable_bit(peb), .bus_width_select_bit(bws), .req_pol(req_pol),
        .req_od(req_od), .dual_req(dual_req), .ack_pol(ack_pol), .tx_req(tx_req),
        .rx_req(rx_req), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_ack(host_ack),
        .port_active(port_active), .sys_hi_o(16'h5A3C), .sys_hi_oe(1'b0),
        .sys_hi_i(sys_hi_i));
    hppi_host hppi_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(hppi_if_inst));
    hppi_monitor hppi_monitor_inst (.pclk(pclk), .presetn(dev_rn),
        .sel_a(hppi_if_inst.sel_a), .sel_b(hppi_if_inst.sel_b), .dir(hppi_if_inst.dir),
        .rd_stb(hppi_if_inst.rd_stb), .wr_stb(hppi_if_inst.wr_stb),
        .ds_stb(hppi_if_inst.ds_stb), .spol(hppi_if_inst.spol), .dual(hppi_if_inst.dual),
        .regsel(hppi_if_inst.regsel), .data_h_o(hppi_if_inst.data_h_o),
        .data_h_oe(hppi_if_inst.data_h_oe), .data_d_oe(hppi_if_inst.data_d_oe));

    // ****************************************
    // Tasks
    // ****************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task close_out();
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            bad_count++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task wait_done();
        logic [31:0] st;
        logic        e;
        int          n;
        st = 32'h1;
        n = 0;
        while (st[0] !== 1'b0 && n < 100) begin
            apb(1'b0, hppi_pkg::OFS_STAT, 32'h0, st, e);
            n++;
        end
        if (st[0] !== 1'b0) begin
            bad_count++;
            close_out();
        end
    endtask

    // One host access; go says whether the device should take it
    task access(input logic [31:0] cfg, input logic rd_n, input logic go);
        logic [3:0]  a;
        logic [15:0] d, m;
        logic [31:0] r;
        logic        e;
        a = 4'($random(seed));
        d = 16'($random(seed));
        m = cfg[hppi_pkg::CB_BYTE] ? 16'h00FF : 16'hFFFF;
        wr(hppi_pkg::OFS_CTRL, cfg);
        repeat (8) @(posedge pclk);
        if (!rd_n) wr(hppi_pkg::OFS_WDATA, 32'(d));
        if (go && rd_n) rq.push_back(a);
        if (go && !rd_n) wq.push_back({a, d & m});
        wr(hppi_pkg::OFS_CTRL, cfg | {20'h0, a, 6'h0, rd_n, 1'b1});
        // Refused while busy
        if (!rd_n) wr(hppi_pkg::OFS_WDATA, 32'(~d));
        wait_done();
        if (rd_n) begin
            apb(1'b0, hppi_pkg::OFS_RDATA, 32'h0, r, e);
            check(r, go ? 32'(mem[a] & m) : 32'(m));
        end
    endtask

    task req_case(input int k);
        logic [2:0]  lv, oe;
        logic [31:0] st;
        logic        e, u, a, l;
        @(posedge pclk);
        req_pol <= k[0];
        req_od <= k[1];
        dual_req <= k[2];
        tx_req <= k[3];
        rx_req <= k[4];
        for (int i = 0; i < 3; i++) begin
            u = k[2] ? (i != 0) : (i == 0);
            a = (i == 0) ? (k[3] | k[4]) : k[2 + i];
            l = a ? k[0] : !k[0];
            lv[i] = u ? l : 1'b1;
            oe[i] = u & (!k[1] | !l);
        end
        repeat (8) @(posedge pclk);
        check(32'(hppi_if_inst.req_lvl), 32'(lv));
        check(32'(hppi_if_inst.req_oe), 32'(oe));
        apb(1'b0, hppi_pkg::OFS_STAT, 32'h0, st, e);
        check(32'(st[3:0]), 32'({lv, 1'b0}));
    endtask

    // ****************************************
    // Result watcher and main sequence
    // ****************************************
    always @(posedge pclk) begin
        if (dev_rn === 1'b1 && reg_wr === 1'b1) begin
            if (wq.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                wn = wq.pop_front();
                check(32'({reg_addr, reg_wdata}), 32'(wn));
            end
        end
        if (dev_rn === 1'b1 && reg_rd === 1'b1) begin
            if (rq.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                check(32'(reg_addr), 32'(rq.pop_front()));
            end
        end
    end

    initial begin
        repeat (90000) @(posedge pclk);
        bad_count++;
        close_out();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        for (int k = 0; k < 16; k++) mem[k] = 16'($random(seed));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        peb <= 1'b1;
        repeat (8) @(posedge pclk);
        check(32'(port_active), 32'h0);
        check(32'(sys_hi_i), 32'hFFFF);
        check(32'(hppi_if_inst.data_d_o), 32'h5A3C);
        access(32'h8, 1'b0, 1'b0);
        access(32'h8, 1'b1, 1'b0);
        bws <= 1'b1;
        repeat (8) @(posedge pclk);
        check(32'(port_active), 32'h1);
        check(32'(sys_hi_i), 32'h0);
        for (int k = 0; k < 16; k++) begin
            access({24'h0, k[3], 2'b00, k[2:0], 2'b00}, 1'b0, 1'b1);
            access({24'h0, k[3], 2'b00, k[2:0], 2'b00}, 1'b1, 1'b1);
        end
        for (int k = 0; k < 32; k++) req_case(k);
        for (int k = 0; k < 8; k++) begin
            ack_pol <= k[0];
            dual_req <= k[2];
            wr(hppi_pkg::OFS_CTRL, {26'h0, k[1], 5'h08});
            repeat (8) @(posedge pclk);
            check(32'(host_ack), 32'(!k[2] && k[1] == k[0]));
        end
        apb(1'b0, 8'h10, 32'h0, r, e);
        check({r[30:0], e}, 32'h1);
        // Strap alone enables the port across a device reset
        wr(hppi_pkg::OFS_CTRL, 32'h48);
        peb <= 1'b0;
        repeat (8) @(posedge pclk);
        dev_rstn <= 1'b0;
        repeat (5) @(posedge pclk);
        dev_rstn <= 1'b1;
        repeat (12) @(posedge pclk);
        check(32'(port_active), 32'h1);
        access(32'h48, 1'b1, 1'b1);
        repeat (20) @(posedge pclk);
        check(32'(wq.size() + rq.size()), 32'h0);
        close_out();
    end
endmodule
